/* core/efta_map.svh */
// What this block does
// - restart loads the program counter with the start address, 16 ticks
// - every program word resets to zero, which decodes as restart
// - end stops the issuing engine after 16 engine ticks
// - send takes exactly 16 ticks; wait takes at least 16 ticks
// - triggers latch until a wait consumes and clears them
// - wait repeats until every selected trigger source has arrived
// - an outgoing external trigger is exactly three ticks low
// - the trigger line is active low, pulled to ground
// - our own outgoing external pulse is never taken as received
// - send plus external wait in one word: send first, then wait
// - wait bits: 7 engine1, 8 engine2, 9 engine3, 12 external
// - send bits: 1 engine1, 2 engine2, 3 engine3, 6 external
// - true jump skips a 5-bit count forward; false goes to next word
// - selector: 0 A, 1 B, 2 global C, 3 variable D or alternate
// - load overwrites target A, B or C with an 8-bit immediate
// - A and B private per engine; C shared by all engines
// - add immediate to target, or add two selected variables
// - sums wrap modulo 256
// - subtract immediate, or first selected minus second selected
// - differences wrap modulo 256
`ifndef EFTA_MAP_SVH
`define EFTA_MAP_SVH
`define EFTA_MCLK_HZ 250000000
`define EFTA_ENG_CLK_KHZ 32
`define EFTA_TICK_DIV (`EFTA_MCLK_HZ / (`EFTA_ENG_CLK_KHZ * 1000))
`define EFTA_SLOT_LAST 4'hf
`define EFTA_TRIG_OUT_TICKS 2'h3
`define EFTA_TRIG_IN_TICKS 2'h2
`define EFTA_MEM_WORDS 8'h60
`define EFTA_MEM_RESET 16'h0000
`define EFTA_REG_CTRL 8'h00
`define EFTA_REG_PC1 8'h37
`define EFTA_REG_PC2 8'h38
`define EFTA_REG_PC3 8'h39
`define EFTA_REG_VAR_D 8'h3c
`define EFTA_REG_ALT_D 8'h42
`define EFTA_REG_START1 8'h4c
`define EFTA_REG_START2 8'h4d
`define EFTA_REG_START3 8'h4e
`define EFTA_REG_MEM_BASE 8'h80
`define EFTA_CTRL_D_ALT 3
`define EFTA_OP_RST 16'h0000
`define EFTA_OP_END 3'h6
`define EFTA_OP_TRIG 3'h7
`define EFTA_OP_JUMP 4'h8
`define EFTA_OP_IMM 4'h9
`define EFTA_OP_VARS 4'ha
`define EFTA_SEND_EXT 6
`define EFTA_WAIT_EXT 12
`endif

/* core/efta_pkg.sv */
package efta_pkg;
  typedef enum logic {EFTA_IDLE, EFTA_RUN} efta_state_t;
  typedef enum logic [1:0] {
    EFTA_SKIP_IF_NOT_EQUAL, EFTA_SKIP_IF_AT_LEAST, EFTA_SKIP_IF_BELOW,
    EFTA_SKIP_IF_EQUAL
  } efta_cond_t;
  typedef enum logic [1:0] {
    EFTA_LOAD_VARIABLE, EFTA_ADD, EFTA_SUB, EFTA_ARITH_NONE
  } efta_arith_t;
  typedef struct packed {
    efta_state_t st;
    logic [6:0] pc;
    logic [3:0] slot;
    logic [7:0] var_a;
    logic [7:0] var_b;
    logic [3:0] latch;
    logic sent;
  } efta_eng_t;
  typedef struct packed {
    efta_eng_t [2:0] eng;
    logic [7:0] var_c;
    logic [7:0] var_d;
    logic [7:0] alt_d;
    logic d_alt;
    logic [2:0][6:0] start;
    logic [95:0][15:0] mem;
    logic [12:0] div;
    logic tick;
    logic [15:0] rdata;
  } efta_top_t;
  typedef struct packed {
    logic [1:0] out_cnt;
    logic oe;
    logic out_lvl;
    logic [1:0] low_cnt;
    logic hit;
  } efta_pin_t;
endpackage

/* core/efta_trig_pin.sv */
`timescale 1ns/1ns
`default_nettype none
`include "efta_map.svh"
module efta_trig_pin (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic send,
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe,
  output logic hit
);
  efta_pkg::efta_pin_t r;
  efta_pkg::efta_pin_t n;

  always_comb begin
    n = r;
    n.hit = 1'b0;
    n.out_lvl = 1'b0;
    if (send) begin
      n.out_cnt = `EFTA_TRIG_OUT_TICKS;
      n.oe = 1'b1;
    end else if (tick && r.oe) begin
      n.out_cnt = r.out_cnt - 2'h1;
      if (r.out_cnt == 2'h1) begin
        n.oe = 1'b0;
      end
    end
    // while we pull the line, its low level is our own
    if (r.oe || send) begin
      n.low_cnt = 2'h0;
    end else if (tick) begin
      if (!trig_i) begin
        if (r.low_cnt != `EFTA_TRIG_IN_TICKS) begin
          n.low_cnt = r.low_cnt + 2'h1;
        end
        if (r.low_cnt == `EFTA_TRIG_IN_TICKS - 2'h1) begin
          n.hit = 1'b1;
        end
      end else begin
        n.low_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign trig_o = r.out_lvl;
  assign trig_oe = r.oe;
  assign hit = r.hit;
endmodule
`default_nettype wire

/* core/efta_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "efta_map.svh"
module efta_top #(
  parameter int unsigned TICK_DIV = `EFTA_TICK_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe
);
  localparam logic [12:0] DIV_LAST = 13'(TICK_DIV - 1);

  efta_pkg::efta_top_t r;
  efta_pkg::efta_top_t n;
  logic send_ext;
  logic ext_hit;
  logic [2:0][3:0] trig_set;

  function automatic logic [7:0] sel_var(
    input logic [1:0] s,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] c,
    input logic [7:0] d
  );
    logic [7:0] v;
    v = d;
    unique case (s)
      2'h0: v = a;
      2'h1: v = b;
      2'h2: v = c;
      2'h3: v = d;
    endcase
    return v;
  endfunction

  // forward skip wraps inside the 96-word program space
  function automatic logic [6:0] step_pc(
    input logic [6:0] pc,
    input logic [4:0] skip
  );
    logic [7:0] s;
    s = {1'b0, pc} + 8'h1 + {3'h0, skip};
    if (s >= `EFTA_MEM_WORDS) begin
      s = s - `EFTA_MEM_WORDS;
    end
    return s[6:0];
  endfunction

  function automatic logic cond_true(
    input logic [1:0] c,
    input logic [7:0] x,
    input logic [7:0] y
  );
    logic t;
    t = 1'b0;
    unique case (efta_pkg::efta_cond_t'(c))
      efta_pkg::EFTA_SKIP_IF_NOT_EQUAL: t = (x != y);
      efta_pkg::EFTA_SKIP_IF_AT_LEAST: t = (x >= y);
      efta_pkg::EFTA_SKIP_IF_BELOW: t = (x < y);
      efta_pkg::EFTA_SKIP_IF_EQUAL: t = (x == y);
    endcase
    return t;
  endfunction

  always_comb begin
    logic [15:0] ins;
    logic [7:0] dv;
    logic [7:0] av;
    logic [7:0] bv;
    logic [7:0] res;
    logic [3:0] need;
    logic [7:0] idx;
    logic wr_res;
    logic [1:0] tgt;
    ins = `EFTA_OP_RST;
    dv = r.d_alt ? r.alt_d : r.var_d;
    av = 8'h0;
    bv = 8'h0;
    res = 8'h0;
    need = 4'h0;
    idx = addr - `EFTA_REG_MEM_BASE;
    wr_res = 1'b0;
    tgt = 2'h0;
    n = r;
    send_ext = 1'b0;
    trig_set = '0;

    // engine tick divider
    if (r.div == DIV_LAST) begin
      n.div = 13'h0;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 13'h1;
      n.tick = 1'b0;
    end

    // register reads: data stand in the following cycle only
    n.rdata = 16'h0;
    if (rd) begin
      if (addr >= `EFTA_REG_MEM_BASE && idx < `EFTA_MEM_WORDS) begin
        n.rdata = r.mem[idx[6:0]];
      end else begin
        case (addr)
          `EFTA_REG_CTRL: begin
            n.rdata = {12'h0, r.d_alt, r.eng[2].st == efta_pkg::EFTA_RUN,
              r.eng[1].st == efta_pkg::EFTA_RUN,
              r.eng[0].st == efta_pkg::EFTA_RUN};
          end
          `EFTA_REG_PC1: n.rdata = {9'h0, r.eng[0].pc};
          `EFTA_REG_PC2: n.rdata = {9'h0, r.eng[1].pc};
          `EFTA_REG_PC3: n.rdata = {9'h0, r.eng[2].pc};
          `EFTA_REG_VAR_D: n.rdata = {8'h0, r.var_d};
          `EFTA_REG_ALT_D: n.rdata = {8'h0, r.alt_d};
          `EFTA_REG_START1: n.rdata = {9'h0, r.start[0]};
          `EFTA_REG_START2: n.rdata = {9'h0, r.start[1]};
          `EFTA_REG_START3: n.rdata = {9'h0, r.start[2]};
          default: n.rdata = 16'h0;
        endcase
      end
    end

    // engines act on the tick; instruction fetched from the current pc
    for (int e = 0; e < 3; e++) begin
      if (r.tick && r.eng[e].st == efta_pkg::EFTA_RUN) begin
        ins = r.mem[r.eng[e].pc];
        av = sel_var(ins[3:2], r.eng[e].var_a, r.eng[e].var_b, r.var_c,
          dv);
        bv = sel_var(ins[1:0], r.eng[e].var_a, r.eng[e].var_b, r.var_c,
          dv);
        // sends go out in the first tick so a paired wait follows them
        if (ins[15:13] == `EFTA_OP_TRIG && r.eng[e].slot == 4'h0 &&
            !r.eng[e].sent) begin
          for (int j = 0; j < 3; j++) begin
            trig_set[j][e] = ins[1 + j];
          end
          send_ext = send_ext | ins[`EFTA_SEND_EXT];
          n.eng[e].sent = 1'b1;
        end
        if (r.eng[e].slot != `EFTA_SLOT_LAST) begin
          n.eng[e].slot = r.eng[e].slot + 4'h1;
        end else begin
          n.eng[e].slot = 4'h0;
          n.eng[e].sent = 1'b0;
          n.eng[e].pc = step_pc(r.eng[e].pc, 5'h0);
          wr_res = 1'b0;
          tgt = ins[9:8];
          if (ins == `EFTA_OP_RST) begin
            n.eng[e].pc = r.start[e];
          end else if (ins[15:13] == `EFTA_OP_END) begin
            n.eng[e].st = efta_pkg::EFTA_IDLE;
            n.eng[e].pc = r.eng[e].pc;
          end else if (ins[15:13] == `EFTA_OP_TRIG) begin
            need = {ins[`EFTA_WAIT_EXT], ins[9:7]};
            if ((r.eng[e].latch & need) == need) begin
              n.eng[e].latch = r.eng[e].latch & ~need;
            end else begin
              // repeat the word; the send already went out once
              n.eng[e].pc = r.eng[e].pc;
              n.eng[e].sent = 1'b1;
            end
          end else if (ins[15:12] == `EFTA_OP_JUMP) begin
            if (cond_true(ins[11:10], av, bv)) begin
              n.eng[e].pc = step_pc(r.eng[e].pc, ins[9:5]);
            end
          end else if (ins[15:12] == `EFTA_OP_IMM) begin
            wr_res = 1'b1;
            av = sel_var(tgt, r.eng[e].var_a, r.eng[e].var_b, r.var_c, dv);
            unique case (efta_pkg::efta_arith_t'(ins[11:10]))
              efta_pkg::EFTA_LOAD_VARIABLE: res = ins[7:0];
              efta_pkg::EFTA_ADD: res = av + ins[7:0];
              efta_pkg::EFTA_SUB: res = av - ins[7:0];
              efta_pkg::EFTA_ARITH_NONE: wr_res = 1'b0;
            endcase
          end else if (ins[15:12] == `EFTA_OP_VARS) begin
            wr_res = 1'b1;
            unique case (efta_pkg::efta_arith_t'(ins[11:10]))
              efta_pkg::EFTA_ADD: res = av + bv;
              efta_pkg::EFTA_SUB: res = av - bv;
              efta_pkg::EFTA_LOAD_VARIABLE: wr_res = 1'b0;
              efta_pkg::EFTA_ARITH_NONE: wr_res = 1'b0;
            endcase
          end
          // target 3 is no variable; copying C back here would undo
          // a write to C by a lower engine in the same tick
          if (wr_res) begin
            unique case (tgt)
              2'h0: n.eng[e].var_a = res;
              2'h1: n.eng[e].var_b = res;
              2'h2: n.var_c = res;
              2'h3: wr_res = 1'b0;
            endcase
          end
        end
      end
    end

    // software writes come after engine updates and so take priority
    if (wr) begin
      if (addr >= `EFTA_REG_MEM_BASE && idx < `EFTA_MEM_WORDS) begin
        n.mem[idx[6:0]] = wdata;
      end else begin
        case (addr)
          `EFTA_REG_CTRL: begin
            n.d_alt = wdata[`EFTA_CTRL_D_ALT];
            for (int e = 0; e < 3; e++) begin
              if (wdata[e] && r.eng[e].st == efta_pkg::EFTA_IDLE) begin
                n.eng[e].st = efta_pkg::EFTA_RUN;
                n.eng[e].slot = 4'h0;
                n.eng[e].sent = 1'b0;
              end else if (!wdata[e]) begin
                n.eng[e].st = efta_pkg::EFTA_IDLE;
              end
            end
          end
          `EFTA_REG_VAR_D: n.var_d = wdata[7:0];
          `EFTA_REG_ALT_D: n.alt_d = wdata[7:0];
          `EFTA_REG_START1: n.start[0] = wdata[6:0];
          `EFTA_REG_START2: n.start[1] = wdata[6:0];
          `EFTA_REG_START3: n.start[2] = wdata[6:0];
          default: n.d_alt = r.d_alt;
        endcase
      end
    end

    // a trigger arriving with a consuming wait still latches
    for (int e = 0; e < 3; e++) begin
      n.eng[e].latch = n.eng[e].latch | trig_set[e] |
        {ext_hit, 3'h0};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  efta_trig_pin u_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(r.tick),
    .send(send_ext),
    .trig_i(trig_i),
    .trig_o(trig_o),
    .trig_oe(trig_oe),
    .hit(ext_hit)
  );

  assign rdata = r.rdata;
endmodule
`default_nettype wire

/* tb/efta_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module efta_top_asserts #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic trig_i,
  input wire logic trig_o,
  input wire logic trig_oe
);
  int cnt;
  // counts cycles of our own pull; overlapping sends are not modelled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else cnt <= trig_oe ? cnt + 1 : 0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_drive_low: assert property (trig_o == 1'b0)
    else $error("trigger drive value not low");
  a_pulse_len: assert property ($fell(trig_oe) |-> cnt == 3 * TICK_DIV)
    else $error("trigger pulse length wrong");
  a_pulse_max: assert property (trig_oe |-> cnt < 3 * TICK_DIV)
    else $error("trigger pulse too long");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_unmapped_read: assert property (rd && addr >= 8'h01 && addr <= 8'h36
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_pc_width: assert property (rd && addr >= 8'h37 && addr <= 8'h39
    |=> rdata[15:7] == 9'h000)
    else $error("pc read too wide");
  a_var_back: assert property (wr && (addr == 8'h3c || addr == 8'h42)
    ##1 rd && addr == $past(addr)
    |=> rdata == ($past(wdata, 2) & 16'h00ff))
    else $error("variable readback wrong");
  a_mem_back: assert property (wr && addr >= 8'h80 && addr <= 8'hdf
    ##1 rd && addr == $past(addr) |=> rdata == $past(wdata, 2))
    else $error("program word readback wrong");
endmodule
`default_nettype wire

/* tb/efta_ext_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module efta_ext_peer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] len,
  output logic pull
);
  logic [7:0] left;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) left <= 8'h00;
    else if (go) left <= len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // open drain: only ever pulls the line to ground
  assign pull = (left != 8'h00);
endmodule
`default_nettype wire

/* tb/engine_flow_trigger_arith_test.sv */
`timescale 1ns/1ns
`default_nettype none
module engine_flow_trigger_arith_test;
  localparam int TD = 4;
  logic mclk, rst_n, wr, rd, trig_oe, trig_o, pull, go;
  logic [7:0] addr, len;
  logic [15:0] wdata, rdata;
  // pull-up on the shared line
  wire logic trig_line = !((trig_oe && !trig_o) || pull);
  int num_errors, total_checks, cyc, va, vb, vc, vd, valt, dalt, b, pc;
  logic [7:0] ra [5] = '{8'h3c, 8'h42, 8'h4d, 8'h95, 8'h20};
  logic [15:0] rm [5] = '{16'h00ff, 16'h00ff, 16'h007f, 16'hffff, 16'h0};
  efta_top #(.TICK_DIV(TD)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig_i(trig_line),
    .trig_o(trig_o), .trig_oe(trig_oe));
  efta_ext_peer peer (.mclk(mclk), .rst_n(rst_n), .go(go), .len(len),
    .pull(pull));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [15:0] v);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    rd <= 1'b0;
    // read data stand one cycle only; look mid-cycle, once settled
    @(negedge mclk);
    chk(rdata, exp);
    @(posedge mclk);
  endtask
  // counts falling edges until the drive enable shows lvl
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (trig_oe !== lvl && n < 300) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic pulse(input int n);
    go <= 1'b1;
    len <= 8'(n);
    @(posedge mclk);
    go <= 1'b0;
    repeat (40 * TD) @(posedge mclk);
  endtask
  function automatic int sv(input int s);
    case (s)
      0: return va;
      1: return vb;
      2: return vc;
      default: return dalt ? valt : vd;
    endcase
  endfunction
  function automatic void put(input int t, input int r);
    if (t == 0) va = r & 255;
    else if (t == 1) vb = r & 255;
    else vc = r & 255;
  endfunction
  // the idle engine sits on its end word, so turn that word into a restart
  task automatic start(input logic [15:0] w0, input logic [15:0] w1);
    b = (b == 16) ? 32 : 16;
    bus(1'b1, 8'h80 + 8'(pc), 16'h0000);
    bus(1'b1, 8'h4c, 16'(b));
    bus(1'b1, 8'h80 + 8'(b), w0);
    bus(1'b1, 8'h81 + 8'(b), w1);
    bus(1'b1, 8'h82 + 8'(b), 16'hc000);
    bus(1'b1, 8'h83 + 8'(b), 16'hc000);
    bus(1'b1, 8'h3c, 16'(vd));
    bus(1'b1, 8'h42, 16'(valt));
    bus(1'b1, 8'h00, 16'(dalt * 8 + 1));
    idle(1);
  endtask
  initial begin
    logic [15:0] w;
    int k, t, j1, j2, c, im, r, tk, n;
    void'($urandom(32'hae99c2e4));
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    go = 1'b0;
    len = 8'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({15'h0, trig_oe}, 16'h0000);
    rdc(8'h37, 16'h0000);
    rdc(8'hdf, 16'h0000);
    foreach (ra[i]) begin
      w = 16'($urandom);
      bus(1'b1, ra[i], w);
      rdc(ra[i], w & rm[i]);
    end
    for (int i = 0; i < 20; i++) begin
      k = i % 5;
      c = i % 4;
      t = $urandom % 3;
      j1 = $urandom % 4;
      j2 = $urandom % 4;
      im = $urandom % 256;
      vd = $urandom % 256;
      valt = $urandom % 256;
      dalt = $urandom % 2;
      if (k < 3) w = 16'h9000 | 16'(k << 10) | 16'(t << 8) | 16'(im);
      else w = 16'ha000 | 16'((k - 2) << 10) | 16'(t << 8) | 16'(j1 * 4 + j2);
      case (k)
        0: r = im;
        1: r = sv(t) + im;
        2: r = sv(t) - im;
        3: r = sv(j1) + sv(j2);
        default: r = sv(j1) - sv(j2);
      endcase
      put(t, r);
      j1 = $urandom % 4;
      j2 = $urandom % 4;
      case (c)
        0: tk = sv(j1) != sv(j2);
        1: tk = sv(j1) >= sv(j2);
        2: tk = sv(j1) < sv(j2);
        default: tk = sv(j1) == sv(j2);
      endcase
      start(w, 16'h8020 | 16'(c << 10) | 16'(j1 * 4 + j2));
      idle(5 * 16 * TD + 20);
      pc = b + 2 + tk;
      rdc(8'h00, 16'(dalt * 8));
      rdc(8'h37, 16'(pc));
    end
    // two sends in a row: rise to rise is one 16-tick word
    start(16'he040, 16'he040);
    wait_oe(1'b1, n);
    wait_oe(1'b0, n);
    tk = n;
    wait_oe(1'b1, n);
    @(posedge mclk);
    chk(16'(tk), 16'(3 * TD));
    chk(16'(tk + n), 16'(16 * TD));
    idle(40 * TD);
    pc = b + 2;
    rdc(8'h37, 16'(pc));
    start(16'hf0c2, 16'hc000);
    wait_oe(1'b1, n);
    wait_oe(1'b0, n);
    @(posedge mclk);
    chk(16'(n), 16'(3 * TD));
    idle(12 * 16 * TD);
    rdc(8'h37, 16'(b));
    pulse(TD - 1);
    rdc(8'h37, 16'(b));
    pulse(3 * TD);
    rdc(8'h00, 16'(dalt * 8));
    pc = b + 1;
    rdc(8'h37, 16'(pc));
    start(16'hf000, 16'hc000);
    idle(12 * 16 * TD);
    rdc(8'h37, 16'(b));
    // engines two and three: private A, shared C, trigger between them
    im = 1 + $urandom % 255;
    bus(1'b1, 8'h4d, 16'h0030);
    bus(1'b1, 8'h4e, 16'h0038);
    bus(1'b1, 8'hb0, 16'h9000 | 16'(im));
    bus(1'b1, 8'hb1, 16'h9200 | 16'(im));
    bus(1'b1, 8'hb2, 16'he008);
    bus(1'b1, 8'hb3, 16'hc000);
    bus(1'b1, 8'hb8, 16'he100);
    bus(1'b1, 8'hb9, 16'h8c2b);
    bus(1'b1, 8'hba, 16'hc000);
    bus(1'b1, 8'hbb, 16'h8023);
    bus(1'b1, 8'hbc, 16'hc000);
    bus(1'b1, 8'hbd, 16'hc000);
    bus(1'b1, 8'h3c, 16'(im));
    bus(1'b1, 8'h00, 16'h0006);
    idle(8 * 16 * TD);
    rdc(8'h00, 16'h0000);
    rdc(8'h38, 16'h0033);
    rdc(8'h39, 16'h003d);
    stop_test();
  end
endmodule
bind efta_top efta_top_asserts #(.TICK_DIV(TICK_DIV)) chk_i (.mclk(mclk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .trig_i(trig_i), .trig_o(trig_o), .trig_oe(trig_oe));
`default_nettype wire
